//--- inc/sra_regs.svh
/*
 * constants for the security register access link: opcodes, bit counts,
 * address fields and busy times. assumes an spi mode 0 link, msb first.
 */
`ifndef SRA_REGS_SVH
`define SRA_REGS_SVH
`define SRA_OP_WREN 8'h06
`define SRA_OP_RDSR 8'h05
`define SRA_OP_ERASE 8'h44
`define SRA_OP_PROG 8'h42
`define SRA_OP_READ 8'h48
`define SRA_OP_LAST 6'h07
`define SRA_OP_BITS 6'h08
`define SRA_HDR_LAST 6'h1F
`define SRA_HDR_BITS 6'h20
`define SRA_RD_BITS 6'h28
`define SRA_BIT_LAST 3'h7
`define SRA_ERASED 8'hFF
`define SRA_A_TOP 23:16
`define SRA_A_SEL 15:12
`define SRA_A_MID 11:8
`define SRA_A_BYTE 7:0
`define SRA_A_IDX 13:12
`define SRA_SEL_MAX 4'h3
`define SRA_CLK_MHZ 10
`define SRA_T_ERASE_US 200
`define SRA_T_PROG_US 100
`define SRA_GAP_CYC 8'h08
`endif

//--- inc/sra_pkg.sv
/*
 * types shared by both ends of the security register access link.
 * assumes nothing beyond the constants header.
 */
`default_nettype none
package sra_pkg;
	// flash end busy state
	typedef enum logic [2:0] {
		SRA_DEV_IDLE = 3'h1,
		SRA_DEV_ERASE = 3'h2,
		SRA_DEV_PROG = 3'h4
	} sra_dev_st_t;
	// host end frame state
	typedef enum logic [3:0] {
		SRA_H_IDLE = 4'h1,
		SRA_H_LOW = 4'h2,
		SRA_H_HIGH = 4'h4,
		SRA_H_GAP = 4'h8
	} sra_host_st_t;
endpackage : sra_pkg
`default_nettype wire

//--- inc/sra_if.sv
/*
 * serial link between the host end and the flash end.
 * assumes the bench ties the two modports; the data line idles high.
 */
`timescale 1ns/1ns
`default_nettype none
interface sra_if;
	logic cs_n; // chip select, low active
	logic sclk; // link clock, made by the host
	logic si; // serial_in_pin
	logic so; // flash output data
	logic so_oe; // flash drives so
	logic so_pin; // level seen on the line
	// weak pull-up when the flash lets go
	assign so_pin = so_oe ? so : 1'b1;
	modport flash (input cs_n, input sclk, input si, output so, output so_oe);
	modport host (output cs_n, output sclk, output si, input so_pin);
endinterface : sra_if
`default_nettype wire

//--- core/sra_flash_end.sv
/*
 * flash end: three otp security registers with erase, program and read,
 * plus write enable and status read for busy polling.
 * assumes a mode 0 host that keeps chip select high for at least three
 * system clocks between frames and stops the link clock outside frames.
 */
// Summary of operation
// - three independent 256-byte registers, separately erasable
// - erase accepted only with write_enable_latch set
// - host sends 44h then 24-bit address
// - address selects register one to three only
// - erase runs only if frame ends exactly
// - chip select rise starts timed erase
// - busy high through cycle, blocks new work
// - status read answers while busy
// - finished cycle clears write_enable_latch
// - locked register ignores erase
// - locked register ignores program
// - program writes one to 256 bytes
// - program accepted only with write_enable_latch set
// - host sends 42h, address, data bytes
// - chip select rise starts timed program
// - host sends 48h, address, eight dummies
// - sample on rise, drive on fall, msb first
// - read index wraps within register
// - read ignored while busy
// - chip select high stops output drive
`timescale 1ns/1ns
`default_nettype none
`include "sra_regs.svh"
module sra_flash_end #(
	parameter int unsigned ERASE_CYC = `SRA_T_ERASE_US * `SRA_CLK_MHZ, // erase busy clocks
	parameter int unsigned PROG_CYC = `SRA_T_PROG_US * `SRA_CLK_MHZ // program busy clocks
) (
	input wire logic i_clk_sys, // system clock
	input wire logic i_sys_rst, // synchronous reset, high
	input wire logic [2:0] i_lock_bits, // otp_lock_bits, one per register
	output logic o_busy, // self-timed cycle running
	output logic o_wel, // write_enable_latch
	output sra_pkg::sra_dev_st_t o_state, // busy state
	sra_if.flash link // serial link
);
	import sra_pkg::*;

	// ****************************************
	// parameter checks
	// ****************************************
	if (ERASE_CYC < 1 || ERASE_CYC > 65535 || PROG_CYC < 1 || PROG_CYC > 65535) begin : g_bad
		$error("busy cycle counts must fit the 16-bit timer");
	end

	// address is legal only for registers one to three
	function automatic logic fmt_ok(input logic [23:0] a);
		fmt_ok = (a[`SRA_A_TOP] == 8'h00) && (a[`SRA_A_MID] == 4'h0) &&
			(a[`SRA_A_SEL] != 4'h0) && (a[`SRA_A_SEL] <= `SRA_SEL_MAX);
	endfunction : fmt_ok

	// ****************************************
	// storage and system side state
	// ****************************************
	logic [7:0] mem_q [1:3][256];
	sra_dev_st_t st_q; // busy state
	logic [15:0] tmr_q; // busy cycles left
	logic wel_q; // write_enable_latch
	logic cs_s1_q, cs_s2_q, cs_s3_q; // chip select synchroniser and edge
	logic [2:0] lock_s1_q, lock_s2_q; // lock pin synchroniser

	// ****************************************
	// link side state
	// ****************************************
	logic [5:0] cnt_q; // header bits seen, saturating
	logic [2:0] bit_q; // data bit within byte
	logic [22:0] sh_q; // incoming bit shifter
	logic [7:0] op_q; // latched opcode
	logic [23:0] addr_q; // latched address
	logic [7:0] idx_q; // running byte index
	logic [7:0] pbuf_q [256]; // program page buffer
	logic ok_q; // frame would be valid if it ended now
	logic rd_free_q; // read opened while not busy
	logic bsy_l1_q, bsy_l2_q; // busy into link domain
	logic wel_l1_q, wel_l2_q; // latch into link domain
	logic so_q, so_oe_q; // output data and enable

	// ****************************************
	// link side decode
	// ****************************************
	wire logic [7:0] byte_now; // byte completed by this edge
	wire logic [23:0] addr_now; // address completed by this edge
	wire logic is_rdsr, is_prog, is_read, is_erase; // opcode decode
	wire logic data_ph; // past header and dummies
	wire logic last_bit; // this edge ends a data byte
	wire logic ok_d; // validity after this edge
	wire logic [1:0] sel_ix; // register index, forced legal
	wire logic [7:0] status; // status byte seen by host
	wire logic [7:0] out_byte; // byte being shifted out
	wire logic out_en; // this frame may drive data
	assign byte_now = {sh_q[6:0], link.si};
	assign addr_now = {sh_q, link.si};
	assign is_rdsr = op_q == `SRA_OP_RDSR;
	assign is_prog = op_q == `SRA_OP_PROG;
	assign is_read = op_q == `SRA_OP_READ;
	assign is_erase = op_q == `SRA_OP_ERASE;
	assign data_ph = (is_rdsr && cnt_q >= `SRA_OP_BITS) ||
		(is_prog && cnt_q >= `SRA_HDR_BITS) ||
		(is_read && cnt_q == `SRA_RD_BITS);
	assign last_bit = bit_q == `SRA_BIT_LAST;
	// valid end points: after opcode, after address, after a whole data byte
	assign ok_d = (cnt_q == `SRA_OP_LAST && byte_now == `SRA_OP_WREN) ||
		(cnt_q == `SRA_HDR_LAST && is_erase && fmt_ok(addr_now)) ||
		(is_prog && data_ph && last_bit && fmt_ok(addr_q));
	assign sel_ix = (addr_q[`SRA_A_IDX] == 2'h0) ? 2'h1 : addr_q[`SRA_A_IDX];
	assign status = {6'h00, wel_l2_q, bsy_l2_q};
	// memory is only written while busy, and reads are shut off then,
	// so this cross-domain read sees a settled array
	assign out_byte = is_rdsr ? status : mem_q[sel_ix][idx_q];
	assign out_en = is_rdsr || (is_read && rd_free_q && fmt_ok(addr_q));

	// counters, cleared whenever chip select is high
	always_ff @(posedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			cnt_q <= 6'h00;
			bit_q <= 3'h0;
		end else begin
			if (cnt_q != `SRA_RD_BITS)
				cnt_q <= cnt_q + 6'h01;
			if (data_ph)
				bit_q <= bit_q + 3'h1;
		end
	end

	// rising edge capture of opcode, address and program data
	always_ff @(posedge link.sclk) begin
		sh_q <= addr_now[22:0];
		ok_q <= ok_d;
		bsy_l1_q <= o_busy;
		bsy_l2_q <= bsy_l1_q;
		wel_l1_q <= wel_q;
		wel_l2_q <= wel_l1_q;
		if (cnt_q == 6'h00) begin
			// fresh frame: page buffer back to all ones
			for (int i = 0; i < 256; i++)
				pbuf_q[i] <= `SRA_ERASED;
		end
		if (cnt_q == `SRA_OP_LAST) begin
			op_q <= byte_now;
			rd_free_q <= ~bsy_l2_q;
		end
		if (cnt_q == `SRA_HDR_LAST) begin
			addr_q <= addr_now;
			idx_q <= addr_now[`SRA_A_BYTE];
		end
		if (data_ph && last_bit) begin
			idx_q <= idx_q + 8'h01;
			if (is_prog)
				pbuf_q[idx_q] <= byte_now;
		end
	end

	// output enable drops at once when chip select rises
	always_ff @(negedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n)
			so_oe_q <= 1'b0;
		else
			so_oe_q <= data_ph && out_en;
	end

	// falling edge shift out, msb first
	always_ff @(negedge link.sclk) begin
		so_q <= out_byte[~bit_q];
	end

	assign link.so = so_q;
	assign link.so_oe = so_oe_q;

	// ****************************************
	// system side: commit on chip select rise
	// ****************************************
	wire logic cs_rise; // frame just ended
	wire logic commit; // ended on a valid boundary
	wire logic locked; // target register is locked
	wire logic go_we, go_er, go_pg; // accepted actions
	assign cs_rise = cs_s2_q && !cs_s3_q;
	// link side values are frozen while chip select is high
	assign commit = cs_rise && ok_q;
	assign locked = lock_s2_q[sel_ix - 2'h1];
	assign go_we = commit && op_q == `SRA_OP_WREN && !o_busy;
	assign go_er = commit && is_erase && wel_q && !o_busy && !locked;
	assign go_pg = commit && is_prog && wel_q && !o_busy && !locked;

	// pin synchronisers
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
			lock_s1_q <= 3'h0;
			lock_s2_q <= 3'h0;
		end else begin
			cs_s1_q <= link.cs_n;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
			lock_s1_q <= i_lock_bits;
			lock_s2_q <= lock_s1_q;
		end
	end

	// busy sequencer and write enable latch
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st_q <= SRA_DEV_IDLE;
			tmr_q <= 16'h0000;
			wel_q <= 1'b0;
		end else begin
			case (st_q)
				SRA_DEV_IDLE: begin
					if (go_we)
						wel_q <= 1'b1;
					if (go_er) begin
						st_q <= SRA_DEV_ERASE;
						tmr_q <= 16'(ERASE_CYC - 1);
					end else if (go_pg) begin
						st_q <= SRA_DEV_PROG;
						tmr_q <= 16'(PROG_CYC - 1);
					end
				end
				SRA_DEV_ERASE, SRA_DEV_PROG: begin
					if (tmr_q == 16'h0000) begin
						st_q <= SRA_DEV_IDLE;
						wel_q <= 1'b0;
					end else begin
						tmr_q <= tmr_q - 16'h0001;
					end
				end
				default: st_q <= SRA_DEV_IDLE;
			endcase
		end
	end

	// array update at the start of the cycle; program only clears bits
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			for (int r = 1; r <= 3; r++)
				for (int i = 0; i < 256; i++)
					mem_q[r][i] <= `SRA_ERASED;
		end else if (go_er) begin
			for (int i = 0; i < 256; i++)
				mem_q[sel_ix][i] <= `SRA_ERASED;
		end else if (go_pg) begin
			for (int i = 0; i < 256; i++)
				mem_q[sel_ix][i] <= mem_q[sel_ix][i] & pbuf_q[i];
		end
	end

	assign o_busy = st_q != SRA_DEV_IDLE;
	assign o_wel = wel_q;
	assign o_state = st_q;
endmodule : sra_flash_end
`default_nettype wire

//--- core/sra_host_end.sv
/*
 * host end: runs one command frame on the link, making the link clock
 * by dividing the system clock. assumes the user orders write enable
 * before erase or program and polls status before the next one.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sra_regs.svh"
module sra_host_end #(
	parameter int unsigned HALF = 4 // system clocks per link clock half
) (
	input wire logic i_clk_sys, // system clock
	input wire logic i_sys_rst, // synchronous reset, high
	input wire logic i_cmd_valid, // command request
	output logic o_cmd_ready, // idle, command taken
	input wire logic [7:0] i_cmd_op, // opcode
	input wire logic [23:0] i_cmd_addr, // address
	input wire logic [8:0] i_cmd_nbytes, // data bytes to send or read
	input wire logic i_wr_valid, // program byte offered
	input wire logic [7:0] i_wr_data, // program byte
	output logic o_wr_ready, // program byte taken
	output logic [7:0] o_rd_data, // byte read back
	output logic o_rd_valid, // read byte pulse
	output sra_pkg::sra_host_st_t o_state, // frame state
	sra_if.host link // serial link
);
	import sra_pkg::*;

	if (HALF < 2 || HALF > 255) begin : g_bad
		$error("HALF must be 2 to 255");
	end

	// ****************************************
	// state
	// ****************************************
	sra_host_st_t st_q; // frame state
	logic [7:0] div_q; // half period counter
	logic [39:0] hdr_q; // opcode, address, dummy shifter
	logic [5:0] nbit_q; // header bits left
	logic [11:0] dbit_q; // data bits left
	logic [7:0] op_q, tx_q, rx_q; // opcode, send and receive bytes
	logic have_q; // program byte loaded
	logic cs_n_q, sclk_q, si_q; // link pins
	logic so_s1_q, so_s2_q; // data line synchroniser
	logic rd_v_q; // read strobe

	// ****************************************
	// decode
	// ****************************************
	wire logic [7:0] half_last; // end of a half period
	wire logic is_prog; // frame sends data
	wire logic need; // waiting for a program byte
	wire logic last; // bit now ending is the frame's last
	wire logic [5:0] hlen; // header length of the new command
	assign half_last = 8'(HALF - 1);
	assign is_prog = op_q == `SRA_OP_PROG;
	assign need = is_prog && nbit_q == 6'h00 && dbit_q[2:0] == 3'h0 && !have_q;
	assign last = (nbit_q == 6'h00 && dbit_q == 12'h001) ||
		(nbit_q == 6'h01 && dbit_q == 12'h000);
	assign hlen = (i_cmd_op == `SRA_OP_READ) ? `SRA_RD_BITS :
		(i_cmd_op == `SRA_OP_ERASE || i_cmd_op == `SRA_OP_PROG) ? `SRA_HDR_BITS :
		`SRA_OP_BITS;
	assign o_cmd_ready = st_q == SRA_H_IDLE;
	assign o_wr_ready = st_q == SRA_H_LOW && need && dbit_q != 12'h000;

	// frame sequencer
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st_q <= SRA_H_IDLE;
			div_q <= 8'h00;
			nbit_q <= 6'h00;
			dbit_q <= 12'h000;
			have_q <= 1'b0;
			cs_n_q <= 1'b1;
			rd_v_q <= 1'b0;
			o_rd_data <= 8'h00;
			// known levels, so the data pin never shows an unknown between headers
			op_q <= 8'h00;
			tx_q <= 8'h00;
			rx_q <= 8'h00;
		end else begin
			rd_v_q <= 1'b0;
			case (st_q)
				SRA_H_IDLE: begin
					if (i_cmd_valid) begin
						// msb first: opcode, address, dummy byte
						hdr_q <= {i_cmd_op, i_cmd_addr, 8'h00};
						op_q <= i_cmd_op;
						nbit_q <= hlen;
						dbit_q <= {i_cmd_nbytes, 3'h0};
						have_q <= 1'b0;
						cs_n_q <= 1'b0;
						div_q <= 8'h00;
						st_q <= SRA_H_LOW;
					end
				end
				SRA_H_LOW: begin
					if (o_wr_ready && i_wr_valid) begin
						tx_q <= i_wr_data;
						have_q <= 1'b1;
					end
					// stalled with the clock low until a byte arrives
					if (!o_wr_ready && div_q == half_last) begin
						div_q <= 8'h00;
						st_q <= SRA_H_HIGH;
					end else if (!o_wr_ready) begin
						div_q <= div_q + 8'h01;
					end
				end
				SRA_H_HIGH: begin
					if (div_q == half_last) begin
						div_q <= 8'h00;
						rx_q <= {rx_q[6:0], so_s2_q};
						if (nbit_q == 6'h00 && dbit_q[2:0] == 3'h1 && !is_prog) begin
							o_rd_data <= {rx_q[6:0], so_s2_q};
							rd_v_q <= 1'b1;
						end
						if (nbit_q != 6'h00) begin
							hdr_q <= {hdr_q[38:0], 1'b0};
							nbit_q <= nbit_q - 6'h01;
						end else begin
							tx_q <= {tx_q[6:0], 1'b0};
							dbit_q <= dbit_q - 12'h001;
							if (dbit_q[2:0] == 3'h1)
								have_q <= 1'b0;
						end
						if (last) begin
							// chip select rises on the next clock, with the clock's fall
							st_q <= SRA_H_GAP;
						end else begin
							st_q <= SRA_H_LOW;
						end
					end else begin
						div_q <= div_q + 8'h01;
					end
				end
				SRA_H_GAP: begin
					// raised with the clock's fall: the clock never stands high deselected
					cs_n_q <= 1'b1;
					// chip select high long enough for the flash to see it
					if (div_q == `SRA_GAP_CYC)
						st_q <= SRA_H_IDLE;
					else
						div_q <= div_q + 8'h01;
				end
				default: st_q <= SRA_H_IDLE;
			endcase
		end
	end

	// pin flops and data line synchroniser
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			sclk_q <= 1'b0;
			si_q <= 1'b0;
			so_s1_q <= 1'b1;
			so_s2_q <= 1'b1;
		end else begin
			sclk_q <= st_q == SRA_H_HIGH;
			si_q <= (nbit_q != 6'h00) ? hdr_q[39] : tx_q[7];
			so_s1_q <= link.so_pin;
			so_s2_q <= so_s1_q;
		end
	end

	assign link.cs_n = cs_n_q;
	assign link.sclk = sclk_q;
	assign link.si = si_q;
	assign o_rd_valid = rd_v_q;
	assign o_state = st_q;
endmodule : sra_host_end
`default_nettype wire

//--- verification/sra_link_sva.sv
/*
 * checker for the security register link, watching the wire signals only.
 * assumes the host divides the system clock by HALF for each link clock half.
 */
`timescale 1ns/1ns
`default_nettype none
module sra_link_sva #(
	parameter int unsigned HALF = 4 // system clocks per link clock half
) (
	input wire logic i_clk_sys, // system clock
	input wire logic i_sys_rst, // synchronous reset, high
	input wire logic cs_n, // chip select, low active
	input wire logic sclk, // link clock
	input wire logic si, // serial_in_pin
	input wire logic so, // flash data
	input wire logic so_oe, // flash drive enable
	input wire logic so_pin // resolved data line
);
	// ****************
	// helper counters
	// ****************
	logic sclk_q; // link clock one sample back
	logic [3:0] hi_cnt_q; // samples in the current high phase
	logic [15:0] rise_cnt_q; // link clock rises in this frame
	wire logic sclk_rise; // rise seen between two samples
	assign sclk_rise = sclk & ~sclk_q;
	// frame count clears while deselected, so it is read at the rise of chip select
	always_ff @(posedge i_clk_sys) begin
		sclk_q <= i_sys_rst ? 1'b0 : sclk;
		hi_cnt_q <= (i_sys_rst || !sclk) ? 4'h0 : hi_cnt_q + 4'h1;
		rise_cnt_q <= (i_sys_rst || cs_n) ? 16'h0000 : rise_cnt_q + {15'h0000, sclk_rise};
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	// ****************
	// wire rules
	// ****************
	idle_clock_low_a: assert property (cs_n |-> !sclk)
		else $error("link clock high outside a frame");
	release_drive_a: assert property (cs_n |-> !so_oe && so_pin)
		else $error("data line driven while deselected");
	gap_hold_a: assert property ($rose(cs_n) |-> cs_n [*8])
		else $error("chip select gap too short");
	whole_bytes_a: assert property ($rose(cs_n) |-> rise_cnt_q[2:0] == 3'h0 && rise_cnt_q != 16'h0000)
		else $error("frame not a whole number of bytes");
	data_start_a: assert property ($rose(so_oe) |-> rise_cnt_q == 16'h0028 || rise_cnt_q == 16'h0008)
		else $error("output started at the wrong bit");
	fall_launch_a: assert property (so_oe && $past(so_oe) && !$fell(sclk) |-> $stable(so))
		else $error("output changed off a falling edge");
	rise_sample_a: assert property (sclk && !cs_n |-> $stable(si))
		else $error("input moved while link clock high");
	half_period_a: assert property ($fell(sclk) |-> hi_cnt_q == 4'(HALF))
		else $error("link clock high phase wrong length");
	read_seen_c: cover property ($rose(so_oe) && rise_cnt_q == 16'h0028);
	status_seen_c: cover property ($rose(so_oe) && rise_cnt_q == 16'h0008);
	erase_frame_c: cover property ($rose(cs_n) && rise_cnt_q == 16'h0020);
endmodule : sra_link_sva
`default_nettype wire

//--- verification/testbench.sv
/*
 * testbench joining host end and flash end over the link interface.
 * assumes shortened busy times; all inputs change on the falling clock edge.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sra_regs.svh"
module testbench;
	import sra_pkg::*;
	localparam int unsigned E_CYC = 900; // erase busy clocks, shortened
	localparam int unsigned P_CYC = 700; // program busy clocks, shortened
	localparam int unsigned HALF = 4; // link clock half period
	logic i_clk_sys = 1'b0; // system clock
	logic i_sys_rst, i_cmd_valid, i_wr_valid; // host controls
	logic [7:0] i_cmd_op, i_wr_data; // opcode and program byte
	logic [23:0] i_cmd_addr; // command address
	logic [8:0] i_cmd_nbytes; // data byte count
	logic [2:0] i_lock_bits; // otp_lock_bits
	logic o_busy, o_wel, o_cmd_ready, o_wr_ready, o_rd_valid; // status outputs
	logic [7:0] o_rd_data; // byte read back
	sra_dev_st_t f_state; // flash state
	sra_host_st_t h_state; // host state
	int bad_count, comparisons, busy_len; // score and busy length
	logic [7:0] rd[$], wq[$], ex[$]; // read, program and expected bytes
	logic [23:0] bad_a[4] = '{24'h004000, 24'h011000, 24'h001100, 24'h000000};
	sra_if link_if();
	sra_flash_end #(.ERASE_CYC(E_CYC), .PROG_CYC(P_CYC)) u_sra_flash_end (
		.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_lock_bits(i_lock_bits),
		.o_busy(o_busy), .o_wel(o_wel), .o_state(f_state), .link(link_if));
	sra_host_end #(.HALF(HALF)) u_sra_host_end (
		.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_cmd_valid(i_cmd_valid),
		.o_cmd_ready(o_cmd_ready), .i_cmd_op(i_cmd_op), .i_cmd_addr(i_cmd_addr),
		.i_cmd_nbytes(i_cmd_nbytes), .i_wr_valid(i_wr_valid), .i_wr_data(i_wr_data),
		.o_wr_ready(o_wr_ready), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
		.o_state(h_state), .link(link_if));
	sra_link_sva #(.HALF(HALF)) u_sra_link_sva (
		.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .cs_n(link_if.cs_n),
		.sclk(link_if.sclk), .si(link_if.si), .so(link_if.so), .so_oe(link_if.so_oe),
		.so_pin(link_if.so_pin));
	always #50 i_clk_sys = ~i_clk_sys;
	// busy length in system clocks, for the timed cycles
	always @(negedge i_clk_sys) if (o_busy === 1'b1) busy_len++;
	// ****************
	// compare tasks
	// ****************
	task automatic chk_flag(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_flag
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic chk_num(input int got, input int exp);
		comparisons++;
		if (got != exp) begin
			bad_count++;
			$display("BAD at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_num
	task automatic chk_rd();
		chk_num(rd.size(), ex.size());
		foreach (ex[i]) chk_byte(rd[i], ex[i]);
	endtask : chk_rd
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done
	// ****************
	// one command frame through the host end
	// ****************
	task automatic run(input logic [7:0] op, input logic [23:0] addr, input int n);
		int k;
		logic took;
		k = 0;
		took = 1'b0;
		rd.delete();
		@(negedge i_clk_sys);
		while (o_cmd_ready !== 1'b1) @(negedge i_clk_sys);
		if (op == `SRA_OP_ERASE || op == `SRA_OP_PROG) busy_len = 0;
		i_cmd_op = op;
		i_cmd_addr = addr;
		i_cmd_nbytes = n[8:0];
		i_cmd_valid = 1'b1;
		i_wr_valid = (op == `SRA_OP_PROG) && (n > 0);
		if (n > 0 && wq.size() > 0) i_wr_data = wq[0];
		@(negedge i_clk_sys);
		i_cmd_valid = 1'b0;
		// program bytes advance one negedge after the edge that took them
		for (int t = 0; t < 20000; t++) begin
			if (took) begin
				k++;
				i_wr_valid = (k < n);
				if (k < n) i_wr_data = wq[k];
			end
			took = (o_wr_ready === 1'b1) && i_wr_valid;
			if (o_rd_valid === 1'b1) rd.push_back(o_rd_data);
			if (o_cmd_ready === 1'b1) break;
			@(negedge i_clk_sys);
		end
		chk_flag(o_cmd_ready, 1'b1);
	endtask : run
	task automatic wait_idle(input int exp_len);
		for (int t = 0; t < 3000 && o_busy === 1'b1; t++) @(negedge i_clk_sys);
		chk_num(busy_len, exp_len);
		chk_flag(o_busy, 1'b0);
	endtask : wait_idle
	// watchdog well beyond the expected run of under one millisecond
	initial begin
		#5000000;
		bad_count++;
		test_done();
	end
	initial begin
		i_sys_rst = 1'b1;
		i_cmd_valid = 1'b0;
		i_cmd_op = 8'h00;
		i_cmd_addr = 24'h000000;
		i_cmd_nbytes = 9'h000;
		i_wr_valid = 1'b0;
		i_wr_data = 8'h00;
		i_lock_bits = 3'h0;
		repeat (12) @(negedge i_clk_sys);
		i_sys_rst = 1'b0;
		repeat (3) @(negedge i_clk_sys);
		chk_flag(o_busy, 1'b0);
		chk_flag(o_wel, 1'b0);
		chk_flag(link_if.cs_n, 1'b1);
		chk_byte({4'h0, h_state}, {4'h0, SRA_H_IDLE});
		chk_byte({5'h00, f_state}, {5'h00, SRA_DEV_IDLE});
		ex = '{8'hFF, 8'hFF};
		run(`SRA_OP_READ, 24'h0010FF, 2);
		chk_rd();
		run(`SRA_OP_ERASE, 24'h001000, 0);
		chk_flag(o_busy, 1'b0);
		$display("test reset done");
		// program across the byte index wrap, read while busy
		run(`SRA_OP_WREN, 24'h000000, 0);
		chk_flag(o_wel, 1'b1);
		wq = '{8'hA5, 8'h3C, 8'h0F};
		run(`SRA_OP_PROG, 24'h0020FE, 3);
		chk_flag(o_busy, 1'b1);
		chk_byte({5'h00, f_state}, {5'h00, SRA_DEV_PROG});
		ex = '{8'hFF};
		run(`SRA_OP_READ, 24'h0020FE, 1);
		chk_rd();
		wait_idle(P_CYC);
		chk_flag(o_wel, 1'b0);
		ex = '{8'hA5, 8'h3C, 8'h0F, 8'hFF};
		run(`SRA_OP_READ, 24'h0020FE, 4);
		chk_rd();
		$display("test program done");
		// erase with one status read while busy
		run(`SRA_OP_WREN, 24'h000000, 0);
		run(`SRA_OP_ERASE, 24'h0020AB, 0);
		chk_flag(o_busy, 1'b1);
		chk_byte({5'h00, f_state}, {5'h00, SRA_DEV_ERASE});
		ex = '{8'h03};
		run(`SRA_OP_RDSR, 24'h000000, 1);
		chk_rd();
		wait_idle(E_CYC);
		chk_flag(o_wel, 1'b0);
		ex = '{8'hFF, 8'hFF, 8'hFF};
		run(`SRA_OP_READ, 24'h0020FE, 3);
		chk_rd();
		$display("test erase done");
		// refused frames leave the latch set and start nothing
		run(`SRA_OP_WREN, 24'h000000, 0);
		foreach (bad_a[i]) begin
			run(`SRA_OP_ERASE, bad_a[i], 0);
			chk_flag(o_busy, 1'b0);
		end
		run(`SRA_OP_ERASE, 24'h001000, 1);
		chk_flag(o_busy, 1'b0);
		run(`SRA_OP_PROG, 24'h001000, 0);
		chk_flag(o_busy, 1'b0);
		i_lock_bits = 3'h4;
		wq = '{8'h11};
		run(`SRA_OP_PROG, 24'h003000, 1);
		chk_flag(o_busy, 1'b0);
		run(`SRA_OP_ERASE, 24'h003000, 0);
		chk_flag(o_busy, 1'b0);
		chk_flag(o_wel, 1'b1);
		wq = '{8'h5A};
		run(`SRA_OP_PROG, 24'h001005, 1);
		wait_idle(P_CYC);
		ex = '{8'h5A};
		run(`SRA_OP_READ, 24'h001005, 1);
		chk_rd();
		ex = '{8'hFF};
		run(`SRA_OP_READ, 24'h003000, 1);
		chk_rd();
		$display("test refusals done");
		test_done();
	end
endmodule : testbench
`default_nettype wire
